// file: hw/spare_amp_switch_monitor.v
// spare amplifier switch-over controller with wishbone registers
//
// What this block does
// - each channel is judged by its pilot-tone detector ok input
// - all healthy: no relay, no audio switch, no channel led or contact
// - status leds steady on while all configured systems are healthy
// - one defective channel, spare ok: relay, led, contact of that channel
// - audio input switched only in multi-channel mode
// - external tone mode: relays only, no audio switch, no tone generator
// - single recoverable failure: slow blink, 2 s, system contact closed
// - spare alone defective: no substitution, spare contact and led on
// - several defective in one system: only its lowest numbered channel is substituted
// - unrecoverable: fast blink, 0.5 s, system fault contact open
// - spare plus standard defective: no substitution, spare contact and led on
// - leds show worst state of up to eight systems
// - cascaded modules: only first module drives spare contact and system fault, others keep system contact grounded
// - channel and spare contacts open when inactive, grounded when active
// - system contact grounded while healthy or recoverable, open on unrecoverable fault
// - mode and amps-per-spare ratio come from configuration
`include "spare_amp_regs.vh"
`timescale 1ns/10ps
module spare_amp_switch_monitor #(
  parameter [23:0] SLOW_HALF = `CLK_HZ / `MS_PER_S * `SLOW_PERIOD_MS / 2,
  parameter [23:0] FAST_HALF = `CLK_HZ / `MS_PER_S * `FAST_PERIOD_MS / 2
) (
  input  wire                 clk_i,            // 10 mhz clock
  input  wire                 nrst_i,           // async reset, active low
  input  wire                 wb_cyc_i,         // wishbone cycle
  input  wire                 wb_stb_i,         // wishbone strobe
  input  wire                 wb_we_i,          // wishbone write
  input  wire [3:0]           wb_sel_i,         // wishbone byte selects
  input  wire [5:0]           wb_adr_i,         // wishbone byte address
  input  wire [31:0]          wb_dat_i,         // wishbone write data
  output wire [31:0]          wb_dat_o,         // wishbone read data
  output wire                 wb_ack_o,         // wishbone ack
  input  wire [`CH_FLAT-1:0]  ch_ok_i,          // pilot tone seen, per channel
  input  wire [`NUM_SYS-1:0]  spare_ok_i,       // pilot tone seen on spare
  output wire [`CH_FLAT-1:0]  relay_o,          // output relay energised
  output wire [`CH_FLAT-1:0]  audio_sw_o,       // audio input to spare
  output wire [`CH_FLAT-1:0]  fault_led_o,      // channel fault led
  output wire [`CH_FLAT-1:0]  fault_gnd_o,      // channel fault contact grounded
  output wire [`MOD_FLAT-1:0] spare_led_o,      // spare fault led per module
  output wire [`MOD_FLAT-1:0] spare_gnd_o,      // spare contact grounded per module
  output wire [`MOD_FLAT-1:0] spare_system_fault_contact_o, // grounded when ok
  output wire [`NUM_SYS-1:0]  tone_gen_o,       // internal pilot tone enabled
  output wire                 led_front_o,      // front status led
  output wire                 led_rear_o,       // rear status led
  output wire                 irq_o             // level interrupt
);

  reg                 rst_s1_q;
  reg                 rst_s2_q;
  wire                rst_n;
  reg  [10:0]         ctrl_q;
  reg  [`IRQ_W-1:0]   irq_stat_q;
  reg  [`IRQ_W-1:0]   irq_mask_q;
  reg                 irq_q;
  reg                 ack_q;
  reg  [31:0]         dat_q;
  reg  [`CH_FLAT-1:0] ok_q;
  reg  [`NUM_SYS-1:0] spare_ok_q;
  reg  [`CH_FLAT-1:0] relay_q;
  reg  [`CH_FLAT-1:0] audio_q;
  reg  [`CH_FLAT-1:0] led_q;
  reg  [`CH_FLAT-1:0] gnd_q;
  reg  [`MOD_FLAT-1:0] sp_led_q;
  reg  [`MOD_FLAT-1:0] sp_gnd_q;
  reg  [`MOD_FLAT-1:0] sys_gnd_q;
  reg  [`NUM_SYS-1:0] tone_q;
  reg  [23:0]         slow_cnt_q;
  reg  [23:0]         fast_cnt_q;
  reg                 slow_ph_q;
  reg                 fast_ph_q;
  reg                 status_led_q;
  reg                 single_prev_q;
  reg                 unrec_prev_q;
  reg                 healthy_prev_q;

  wire [1:0]          mode;
  wire [2:0]          ratio;
  wire [2:0]          nsys;
  wire [5:0]          ch_lim;
  wire [`NUM_CH-1:0]  ch_en;
  wire [`CH_FLAT-1:0] sub_d;
  wire [`MOD_FLAT-1:0] sp_d;
  wire [`MOD_FLAT-1:0] sys_gnd_d;
  wire [`NUM_SYS-1:0] act;
  wire [`NUM_SYS-1:0] sp_def;
  wire [`NUM_SYS-1:0] single_v;
  wire [`NUM_SYS-1:0] unrec_v;
  wire                single_any;
  wire                unrec_any;
  wire                healthy;
  wire                wb_req;
  wire                wb_wr;
  wire [3:0]          wb_idx;
  wire [`IRQ_W-1:0]   irq_ev;
  wire [`IRQ_W-1:0]   irq_clr;
  wire [`IRQ_W-1:0]   irq_stat_d;
  wire [1:0]          worst;
  wire                multi;
  wire                ext;
  wire                wb_rd;
  wire                ev_single;
  wire                ev_unrec;
  wire                ev_healthy;
  wire [`CH_FLAT-1:0] audio_d;
  wire [`NUM_SYS-1:0] tone_d;
  reg  [31:0]         rd_d;

  // reset release through two flops
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // configuration fields
  assign mode   = ctrl_q[`CTRL_MODE_LSB +: 2];
  assign ratio  = ctrl_q[`CTRL_RATIO_LSB +: 3];
  assign nsys   = ctrl_q[`CTRL_NSYS_LSB +: 3];
  assign ch_lim = {1'b0, ratio, 2'b00} + `CH_PER_MOD;
  assign multi  = (mode == `MODE_MULTI);
  assign ext    = (mode == `MODE_EXT) || (mode == 2'h3);

  genvar c;
  generate
    for (c = 0; c < `NUM_CH; c = c + 1) begin : g_ch
      assign ch_en[c] = (c < ch_lim);
    end
  endgenerate

  // per system: defective set, lowest candidate, severity
  genvar s;
  generate
    for (s = 0; s < `NUM_SYS; s = s + 1) begin : g_sys
      wire [`NUM_CH-1:0] def;
      wire [`NUM_CH-1:0] low;
      wire               more;
      wire               any;
      assign act[s]    = (s <= nsys);
      assign def       = ~ok_q[s*`NUM_CH +: `NUM_CH] & ch_en & {`NUM_CH{act[s]}};
      assign low       = def & (~def + 28'h0000001);
      assign more      = |(def & ~low);
      assign any       = |def;
      assign sp_def[s] = ~spare_ok_q[s] & act[s];
      assign unrec_v[s]  = more | (sp_def[s] & any);
      assign single_v[s] = ~unrec_v[s] & (any | sp_def[s]);
      // spare defective blocks any substitution
      assign sub_d[s*`NUM_CH +: `NUM_CH] = sp_def[s] ? 28'h0000000 : low;
      // only the first module of a system carries spare contact and system fault, the others hold the system contact grounded
      assign sp_d[s*`NUM_MOD +: `NUM_MOD] = {6'h00, sp_def[s]};
      assign sys_gnd_d[s*`NUM_MOD +: `NUM_MOD] =
        {{6{act[s]}}, act[s] & ~unrec_v[s]};
    end
  endgenerate

  assign single_any = |single_v;
  assign unrec_any  = |unrec_v;
  assign healthy    = ~single_any & ~unrec_any;
  assign worst      = unrec_any ? `SEV_UNREC : (single_any ? `SEV_SINGLE : `SEV_OK);

  assign audio_d = multi ? sub_d : {`CH_FLAT{1'b0}};
  assign tone_d  = ext ? {`NUM_SYS{1'b0}} : act;

  // health inputs, sampled every cycle
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ok_q       <= {`CH_FLAT{1'b1}};
      spare_ok_q <= {`NUM_SYS{1'b1}};
    end else if (!rst_n) begin
      ok_q       <= {`CH_FLAT{1'b1}};
      spare_ok_q <= {`NUM_SYS{1'b1}};
    end else begin
      ok_q       <= ch_ok_i;
      spare_ok_q <= spare_ok_i;
    end
  end

  // channel relays, audio switches, leds and contacts, refreshed every cycle
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      relay_q <= {`CH_FLAT{1'b0}};
      audio_q <= {`CH_FLAT{1'b0}};
      led_q   <= {`CH_FLAT{1'b0}};
      gnd_q   <= {`CH_FLAT{1'b0}};
    end else if (!rst_n) begin
      relay_q <= {`CH_FLAT{1'b0}};
      audio_q <= {`CH_FLAT{1'b0}};
      led_q   <= {`CH_FLAT{1'b0}};
      gnd_q   <= {`CH_FLAT{1'b0}};
    end else begin
      relay_q <= sub_d;
      audio_q <= audio_d;
      led_q   <= sub_d;
      gnd_q   <= sub_d;
    end
  end

  // spare and system contacts per module, tone generators
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_led_q  <= {`MOD_FLAT{1'b0}};
      sp_gnd_q  <= {`MOD_FLAT{1'b0}};
      sys_gnd_q <= {`MOD_FLAT{1'b0}};
      tone_q    <= {`NUM_SYS{1'b0}};
    end else if (!rst_n) begin
      sp_led_q  <= {`MOD_FLAT{1'b0}};
      sp_gnd_q  <= {`MOD_FLAT{1'b0}};
      sys_gnd_q <= {`MOD_FLAT{1'b0}};
      tone_q    <= {`NUM_SYS{1'b0}};
    end else begin
      sp_led_q  <= sp_d;
      sp_gnd_q  <= sp_d;
      sys_gnd_q <= sys_gnd_d;
      tone_q    <= tone_d;
    end
  end

  // slow blink divider, free running from reset
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slow_cnt_q <= 24'h000000;
      slow_ph_q  <= 1'b0;
    end else if (slow_cnt_q >= SLOW_HALF - 24'h000001) begin
      slow_cnt_q <= 24'h000000;
      slow_ph_q  <= ~slow_ph_q;
    end else begin
      slow_cnt_q <= slow_cnt_q + 24'h000001;
    end
  end

  // fast blink divider, free running from reset
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_cnt_q <= 24'h000000;
      fast_ph_q  <= 1'b0;
    end else if (fast_cnt_q >= FAST_HALF - 24'h000001) begin
      fast_cnt_q <= 24'h000000;
      fast_ph_q  <= ~fast_ph_q;
    end else begin
      fast_cnt_q <= fast_cnt_q + 24'h000001;
    end
  end

  // status led picks the phase of the worst severity, registered
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_led_q <= 1'b0;
    end else if (!rst_n) begin
      status_led_q <= 1'b0;
    end else if (unrec_any) begin
      status_led_q <= fast_ph_q;
    end else if (single_any) begin
      status_led_q <= slow_ph_q;
    end else begin
      status_led_q <= 1'b1;
    end
  end

  // wishbone slave, one wait state, ack for every address
  assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr   = wb_req & wb_we_i;
  assign wb_idx  = wb_adr_i[5:2];
  assign wb_rd      = wb_req & ~wb_we_i;
  assign ev_single  = single_any & ~single_prev_q;
  assign ev_unrec   = unrec_any & ~unrec_prev_q;
  assign ev_healthy = healthy & ~healthy_prev_q;
  assign irq_ev     = {ev_healthy, ev_unrec, ev_single};
  assign irq_clr = (wb_wr && wb_idx == `ADR_IRQ_STAT && wb_sel_i[0]) ?
                   wb_dat_i[`IRQ_W-1:0] : `IRQ_RST;
  // a new event wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  // interrupt status and severity history
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_q     <= `IRQ_RST;
      irq_q          <= 1'b0;
      single_prev_q  <= 1'b0;
      unrec_prev_q   <= 1'b0;
      healthy_prev_q <= 1'b1;
    end else if (!rst_n) begin
      irq_stat_q     <= `IRQ_RST;
      irq_q          <= 1'b0;
      single_prev_q  <= 1'b0;
      unrec_prev_q   <= 1'b0;
      healthy_prev_q <= 1'b1;
    end else begin
      single_prev_q  <= single_any;
      unrec_prev_q   <= unrec_any;
      healthy_prev_q <= healthy;
      irq_stat_q     <= irq_stat_d;
      irq_q          <= |(irq_stat_d & irq_mask_q);
    end
  end

  // one wait state: ack follows a taken request for exactly one cycle
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
    end else if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // read data of the addressed register
  always @* begin
    rd_d = 32'h00000000;
    case (wb_idx)
      `ADR_CTRL: begin
        rd_d = {21'h000000, ctrl_q};
      end
      `ADR_STATUS: begin
        rd_d = {8'h00, sp_def, (single_v | unrec_v), 6'h00, worst};
      end
      `ADR_IRQ_STAT: begin
        rd_d = {29'h00000000, irq_stat_q};
      end
      `ADR_IRQ_MASK: begin
        rd_d = {29'h00000000, irq_mask_q};
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  // register writes and read data capture
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q     <= `CTRL_RST;
      irq_mask_q <= `IRQ_RST;
      dat_q      <= 32'h00000000;
    end else if (!rst_n) begin
      ctrl_q     <= `CTRL_RST;
      irq_mask_q <= `IRQ_RST;
      dat_q      <= 32'h00000000;
    end else begin
      if (wb_wr && wb_idx == `ADR_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrl_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ctrl_q[10:8] <= wb_dat_i[10:8];
        end
      end
      if (wb_wr && wb_idx == `ADR_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_q <= wb_dat_i[`IRQ_W-1:0];
      end
      if (wb_rd) begin
        dat_q <= rd_d;
      end
    end
  end

  assign wb_dat_o    = dat_q;
  assign wb_ack_o    = ack_q;
  assign relay_o     = relay_q;
  assign audio_sw_o  = audio_q;
  assign fault_led_o = led_q;
  assign fault_gnd_o = gnd_q;
  assign spare_led_o = sp_led_q;
  assign spare_gnd_o = sp_gnd_q;
  assign spare_system_fault_contact_o = sys_gnd_q;
  assign tone_gen_o  = tone_q;
  assign led_front_o = status_led_q;
  assign led_rear_o  = status_led_q;
  assign irq_o       = irq_q;

endmodule

// file: hw/spare_amp_regs.vh
// constants for the spare amplifier switch monitor
`ifndef SPARE_AMP_REGS_VH
`define SPARE_AMP_REGS_VH

`define CLK_HZ          10000000
`define SLOW_PERIOD_MS  2000
`define FAST_PERIOD_MS  500
`define MS_PER_S        1000

`define NUM_SYS         8
`define NUM_CH          28
`define CH_FLAT         224
`define NUM_MOD         7
`define MOD_FLAT        56
`define CH_PER_MOD      6'h04

`define ADR_CTRL        4'h0
`define ADR_STATUS      4'h1
`define ADR_IRQ_STAT    4'h2
`define ADR_IRQ_MASK    4'h3

`define MODE_SINGLE     2'h0
`define MODE_MULTI      2'h1
`define MODE_EXT        2'h2

`define CTRL_MODE_LSB   0
`define CTRL_RATIO_LSB  4
`define CTRL_NSYS_LSB   8
`define CTRL_RST        11'h000

`define ST_SEV_LSB      0
`define ST_BAD_LSB      8
`define ST_SPARE_LSB    16

`define IRQ_W           3
`define IRQ_SINGLE      0
`define IRQ_UNREC       1
`define IRQ_HEALTHY     2
`define IRQ_RST         3'h0

`define SEV_OK          2'h0
`define SEV_SINGLE      2'h1
`define SEV_UNREC       2'h2

`endif

// file: test/spare_amp_chk.sv
// assertion checker bound to the spare amplifier switch monitor
`timescale 1ns/10ps
`include "spare_amp_regs.vh"
module spare_amp_chk (
  input wire logic                 clk_i,       // clock
  input wire logic                 nrst_i,      // reset, low
  input wire logic [`CH_FLAT-1:0]  ch_ok_i,     // channel tone
  input wire logic [`NUM_SYS-1:0]  spare_ok_i,  // spare tone
  input wire logic [`CH_FLAT-1:0]  relay_o,     // relays
  input wire logic [`CH_FLAT-1:0]  audio_sw_o,  // audio switch
  input wire logic [`CH_FLAT-1:0]  fault_led_o, // channel leds
  input wire logic [`CH_FLAT-1:0]  fault_gnd_o, // channel contacts
  input wire logic [`MOD_FLAT-1:0] spare_led_o, // spare leds
  input wire logic [`MOD_FLAT-1:0] spare_gnd_o, // spare contacts
  input wire logic [`MOD_FLAT-1:0] spare_system_fault_contact_o, // system contact
  input wire logic                 led_front_o, // front led
  input wire logic                 led_rear_o   // rear led
);
  logic [2:0] up_q;
  // outputs stay cleared while the reset synchroniser drains
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence all_ok_s;
    up_q == 3'h7 && (&ch_ok_i) && (&spare_ok_i);
  endsequence
  sequence spare_bad_s;
    up_q == 3'h7 && !spare_ok_i[0];
  endsequence
  led_pair_a: assert property (led_front_o == led_rear_o)
    else $error("status leds differ");
  relay_led_a: assert property (relay_o == fault_led_o)
    else $error("relay and fault led differ");
  contact_gnd_a: assert property (fault_gnd_o == relay_o)
    else $error("fault contact and relay differ");
  audio_sub_a: assert property ((audio_sw_o & ~relay_o) == '0)
    else $error("audio switched without relay");
  one_sub_a: assert property ($onehot0(relay_o[27:0]))
    else $error("more than one substitution");
  spare_pair_a: assert property (spare_led_o == spare_gnd_o)
    else $error("spare led and contact differ");
  first_mod_a: assert property (spare_led_o[6:1] == 6'h00)
    else $error("non-first module drives spare led");
  healthy_out_a: assert property (all_ok_s[*2] |-> ##2 relay_o[27:0] == 28'h0
    && spare_system_fault_contact_o[0] && !spare_gnd_o[0]) else $error("healthy outputs wrong");
  steady_led_a: assert property (all_ok_s[*2] |-> ##2 led_front_o)
    else $error("status led not steady");
  spare_bad_a: assert property (spare_bad_s[*2] |-> ##2 relay_o[27:0] == 28'h0
    && spare_gnd_o[0]) else $error("spare fault outputs wrong");
  sub_cause_a: assert property (up_q == 3'h7 && $rose(relay_o[0]) |->
    !$past(ch_ok_i[0], 2) && $past(spare_ok_i[0], 2)) else $error("relay without cause");
endmodule
bind spare_amp_switch_monitor spare_amp_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .ch_ok_i(ch_ok_i), .spare_ok_i(spare_ok_i), .relay_o(relay_o), .audio_sw_o(audio_sw_o),
  .fault_led_o(fault_led_o), .fault_gnd_o(fault_gnd_o), .spare_led_o(spare_led_o),
  .spare_gnd_o(spare_gnd_o), .spare_system_fault_contact_o(spare_system_fault_contact_o),
  .led_front_o(led_front_o), .led_rear_o(led_rear_o));

// file: test/tone_det_model.sv
// behavioural pilot-tone detectors at the amplifier outputs
`timescale 1ns/10ps
`include "spare_amp_regs.vh"
module tone_det_model (
  input  wire logic                 clk_i,     // clock
  input  wire logic                 ext_i,     // external tone present
  input  wire logic [`NUM_SYS-1:0]  gen_i,     // internal generators on
  input  wire logic [`CH_FLAT-1:0]  dead_i,    // amps passing no tone
  input  wire logic [`NUM_SYS-1:0]  dead_sp_i, // spares passing no tone
  output logic      [`CH_FLAT-1:0]  ch_ok_o = '1, // tone seen per channel
  output logic      [`NUM_SYS-1:0]  sp_ok_o = '1  // tone seen per spare
);
  integer s;
  // a tone is seen only if some source feeds it and the amp passes it
  always @(posedge clk_i) begin
    for (s = 0; s < `NUM_SYS; s = s + 1) begin
      ch_ok_o[s*`NUM_CH +: `NUM_CH] <= ~dead_i[s*`NUM_CH +: `NUM_CH]
        & {`NUM_CH{ext_i | gen_i[s]}};
      sp_ok_o[s] <= !dead_sp_i[s] && (ext_i || gen_i[s]);
    end
  end
endmodule

// file: test/spare_amp_switch_monitor_test.sv
// self-checking bench for the spare amplifier switch monitor
`timescale 1ns/10ps
`include "spare_amp_regs.vh"
module spare_amp_switch_monitor_test;
  logic                 clk_i = 1'b0;
  logic                 nrst_i = 1'b0;
  logic                 cyc = 1'b0;
  logic                 we = 1'b0;
  logic                 ext = 1'b0;
  logic [5:0]           adr = 6'h00;
  logic [31:0]          wdat = 32'h0;
  logic [31:0]          rdat, dat_o;
  logic                 ack, led_f, led_r, irq;
  logic [`CH_FLAT-1:0]  dead = '0;
  logic [`CH_FLAT-1:0]  ch_ok, relay, audio, fled, fgnd;
  logic [`NUM_SYS-1:0]  dead_sp = '0;
  logic [`NUM_SYS-1:0]  sp_ok, gen;
  logic [`MOD_FLAT-1:0] sled, sgnd, sysc;
  integer               error_cnt = 0;
  integer               cmp_count = 0;
  always #50 clk_i = ~clk_i;
  tone_det_model det_u (.clk_i(clk_i), .ext_i(ext), .gen_i(gen), .dead_i(dead),
    .dead_sp_i(dead_sp), .ch_ok_o(ch_ok), .sp_ok_o(sp_ok));
  spare_amp_switch_monitor #(.SLOW_HALF(24'h000008), .FAST_HALF(24'h000002)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ch_ok_i(ch_ok), .spare_ok_i(sp_ok), .relay_o(relay), .audio_sw_o(audio),
    .fault_led_o(fled), .fault_gnd_o(fgnd), .spare_led_o(sled), .spare_gnd_o(sgnd),
    .spare_system_fault_contact_o(sysc), .tone_gen_o(gen), .led_front_o(led_f),
    .led_rear_o(led_r), .irq_o(irq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cfg(input logic [1:0] m, input logic [2:0] r, input logic [2:0] s);
    wb(1'b1, 6'h00, {21'h0, s, 1'b0, r, 2'h0, m});
    ext <= m[1];
    wb(1'b0, 6'h00, 32'h0);
    chk("ctrl", {21'h0, s, 1'b0, r, 2'h0, m}, rdat);
    tick(5);
  endtask
  task automatic blink(input int h);
    logic v;
    int n;
    n = 0;
    v = led_f;
    while (led_f === v && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    v = led_f;
    n = 0;
    while (led_f === v && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("half period", h, n);
  endtask
  task automatic t_regs();
    wb(1'b0, 6'h0c, 32'h0);
    chk("mask reset", 32'h0, rdat);
    wb(1'b1, 6'h10, 32'hffffffff);
    wb(1'b0, 6'h10, 32'h0);
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic t_sub(input logic [1:0] m);
    cfg(m, 3'h1, 3'h1);
    dead[5] <= 1'b1;
    tick(5);
    chk("relay", 32'h20, relay[31:0]);
    chk("fault led", 32'h20, fled[31:0]);
    chk("audio", (m == `MODE_MULTI) ? 32'h20 : 32'h0, audio[31:0]);
    chk("tone gen", m[1] ? 32'h0 : 32'h3, {24'h0, gen});
    chk("sys contact", 32'h7f, {25'h0, sysc[6:0]});
    blink(8);
    wb(1'b0, 6'h04, 32'h0);
    chk("status", 32'h101, rdat);
    dead <= '0;
    tick(5);
    chk("release", 32'h0, relay[31:0]);
  endtask
  task automatic t_multi();
    cfg(`MODE_MULTI, 3'h1, 3'h1);
    dead[34] <= 1'b1;
    dead[30] <= 1'b1;
    dead[37] <= 1'b1;
    tick(5);
    chk("lowest relay", 32'h4, relay[59:28]);
    chk("lowest audio", 32'h4, audio[59:28]);
    chk("sys contact", 32'h7e, {25'h0, sysc[13:7]});
    blink(2);
    wb(1'b0, 6'h04, 32'h0);
    chk("status", 32'h202, rdat);
    dead <= '0;
  endtask
  task automatic t_spare();
    cfg(`MODE_SINGLE, 3'h0, 3'h0);
    dead_sp[0] <= 1'b1;
    tick(5);
    chk("relay", 32'h0, relay[31:0]);
    chk("spare", 32'h3, {30'h0, sled[0], sgnd[0]});
    chk("sys contact", 32'h1, {31'h0, sysc[0]});
    blink(8);
    dead[0] <= 1'b1;
    tick(5);
    chk("relay", 32'h0, relay[31:0]);
    chk("spare", 32'h3, {30'h0, sled[0], sgnd[0]});
    chk("sys contact", 32'h0, {31'h0, sysc[0]});
    blink(2);
    dead <= '0;
    dead_sp <= '0;
  endtask
  task automatic t_irq();
    cfg(`MODE_EXT, 3'h0, 3'h0);
    wb(1'b1, 6'h08, 32'h7);
    wb(1'b1, 6'h0c, 32'h5);
    chk("irq idle", 32'h0, {31'h0, irq});
    dead[0] <= 1'b1;
    tick(5);
    chk("relay", 32'h1, relay[31:0]);
    chk("irq set", 32'h1, {31'h0, irq});
    wb(1'b1, 6'h08, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq});
    dead <= '0;
    tick(20);
    chk("leds", 32'h3, {30'h0, led_f, led_r});
    chk("idle relay", 32'h0, relay[31:0]);
    chk("irq healthy", 32'h1, {31'h0, irq});
  endtask
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    tick(4);
    t_regs();
    for (int m = 0; m < 4; m++) t_sub(m[1:0]);
    t_multi();
    t_spare();
    t_irq();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule
